// ### dv/lnini_far_end.sv
// Far lane model: emits decoded words and the no-signal level.
// Assumes the bench commands at most one word per cycle.
`timescale 1ns/1ps

module lnini_far_end (
    input  wire logic                   i_clk,      // Lane clock
    input  wire logic                   i_send,     // Word this cycle
    input  wire lnini_pkg::lnini_word_t i_kind,     // Word to send
    input  wire logic                   i_quiet,    // Far end silent
    output lnini_pkg::lnini_rxw_t       o_word,     // Decoded word
    output logic                        o_no_signal // High when silent
);
    lnini_pkg::lnini_word_t last_q = lnini_pkg::W_OTHER;

    // Idle kind toggles so a stale word never looks held
    always_ff @(posedge i_clk)
    begin
        last_q <= i_send ? i_kind : lnini_pkg::lnini_word_t'(~last_q);
    end

    assign o_word      = '{valid: i_send, kind: i_send ? i_kind : last_q};
    assign o_no_signal = i_quiet;
endmodule

// ### dv/tb.sv
// Self-checking bench for the lane bring-up state machine.
// Assumes lnini_far_end stands in for the remote lane.
`timescale 1ns/1ps

module tb;
    logic        clk = 0, srst = 1, cyc = 0, stb = 0, we = 0;
    logic        send = 0, quiet = 1, ack, nosig, load;
    logic [7:0]  adr = 8'h00, ecnt;
    logic [31:0] wdat = 32'h0000_0000, rdat, rd, v, seed = 32'h0001_5EFB;
    int          n_mismatch = 0, checks_done = 0;
    lnini_pkg::lnini_word_t  kind = lnini_pkg::W_OTHER, kd;
    lnini_pkg::lnini_rxw_t   rxw;
    lnini_pkg::lnini_lane_t  lane;
    lnini_pkg::lnini_state_t st;

    lnini_core i_lnini_core (.I_CLK(clk), .I_SRST(srst), .I_WB_CYC(cyc),
        .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF),
        .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .I_NO_SIGNAL(nosig), .I_RX_WORD(rxw), .O_LANE(lane), .O_STATE(st),
        .O_RECEIVE_ERROR_WORD_CNT(ecnt), .O_RECEIVE_ERROR_WORD_LOAD(load));
    lnini_far_end i_lnini_far_end (.i_clk(clk), .i_send(send),
        .i_kind(kind), .i_quiet(quiet), .o_word(rxw), .o_no_signal(nosig));

    initial
    begin
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'h1);
        rd = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask

    task automatic words(input lnini_pkg::lnini_word_t k, input int cnt);
        repeat (cnt)
        begin
            @(posedge clk);
            send <= 1'h1;
            kind <= k;
        end
        @(posedge clk);
        send <= 1'h0;
    endtask

    task automatic wst(input lnini_pkg::lnini_state_t s, input int lim = 8);
        int n = 0;
        do @(negedge clk); while (st !== s && n++ < lim);
        chk(32'(st), 32'(s));
    endtask

    // Time spent in a state, in clock cycles
    task automatic dwell(input lnini_pkg::lnini_state_t s, input int exp);
        int n = 0;
        wst(s);
        while (st === s && n < 1000)
        begin
            @(negedge clk);
            n++;
        end
        chk(n, exp);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        srst <= 1'h0;
        dwell(lnini_pkg::ST_FLUSH, lnini_pkg::FLUSH_CYC);
        chk(32'(lane), 32'h0000_0000);
        $display("test flush done");
        v = (xs() % 255) + 1;
        wb(1'h1, lnini_pkg::ADR_RXE, v);
        wb(1'h1, lnini_pkg::ADR_CTRL, 32'h0000_0002);
        wst(lnini_pkg::ST_WAIT);
        chk(32'(lane), 32'h0000_001C);
        wb(1'h1, lnini_pkg::ADR_CTRL, 32'h0000_0000);
        wst(lnini_pkg::ST_DIS);
        wb(1'h1, lnini_pkg::ADR_CTRL, 32'h0000_0002);
        wst(lnini_pkg::ST_WAIT);
        @(posedge clk);
        quiet <= 1'h0;
        wst(lnini_pkg::ST_START);
        chk(load, 1'h1);
        chk(32'(lane), 32'h0000_007D);
        chk(32'(ecnt), v);
        wb(1'h0, 8'h0C, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        kd = xs() & 1 ? lnini_pkg::W_FIRST_HANDSHAKE_WORD : lnini_pkg::W_SECOND_HANDSHAKE_WORD;
        words(kd, 2);
        words(lnini_pkg::W_RECEIVE_ERROR_WORD, 1);
        words(kd, 2);
        @(negedge clk);
        chk(32'(st), 32'(lnini_pkg::ST_START));
        words(kd, 1);
        wst(lnini_pkg::ST_CONN);
        $display("test bring-up done");
        wb(1'h1, lnini_pkg::ADR_CTRL, 32'h0000_000A);
        wst(lnini_pkg::ST_FLUSH);
        wst(lnini_pkg::ST_START, 60);
        kd = xs() & 1 ? lnini_pkg::W_NINIT1 : lnini_pkg::W_NINIT2;
        words(kd, 3);
        wst(lnini_pkg::ST_FLIP);
        chk(lane.rx_inv, 1'h1);
        wb(1'h1, lnini_pkg::ADR_CTRL, 32'h0000_000A);
        wst(lnini_pkg::ST_FLUSH);
        chk(lane.rx_inv, 1'h0);
        wst(lnini_pkg::ST_START, 60);
        wb(1'h1, lnini_pkg::ADR_CTRL, 32'h0000_000E);
        wst(lnini_pkg::ST_COLD);
        wst(lnini_pkg::ST_DIS, 60);
        wb(1'h1, lnini_pkg::ADR_CTRL, 32'h0000_0008);
        wst(lnini_pkg::ST_FLUSH);
        wst(lnini_pkg::ST_DIS, 60);
        $display("test resets done");
        @(posedge clk);
        quiet <= 1'h1;
        wb(1'h1, lnini_pkg::ADR_CTRL, 32'h0000_0001);
        dwell(lnini_pkg::ST_START, lnini_pkg::TMO_CYC);
        chk(32'(st), 32'(lnini_pkg::ST_FLUSH));
        wst(lnini_pkg::ST_START, 60);
        words(lnini_pkg::W_LOS, 7);
        words(lnini_pkg::W_OTHER, 1);
        words(lnini_pkg::W_LOS, 7);
        @(negedge clk);
        chk(32'(st), 32'(lnini_pkg::ST_START));
        words(lnini_pkg::W_LOS, 1);
        wst(lnini_pkg::ST_FLUSH);
        $display("test timeout and drop done");
        tally_and_finish();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule

// ### src/lnini_core.sv
// Lane bring-up state machine: cold reset, flush, Disabled, Wait, Started, polarity flip and Connecting states.
// Assumes a Wishbone master on I_CLK and received words on I_CLK.
//
// Our own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps

module lnini_core (
    input  wire logic               I_CLK,       // 20 MHz clock
    input  wire logic               I_SRST,      // Sync reset, high
    input  wire logic               I_WB_CYC,    // Bus cycle
    input  wire logic               I_WB_STB,    // Bus strobe
    input  wire logic               I_WB_WE,     // Write enable
    input  wire logic [7:0]         I_WB_ADR,    // Byte address
    input  wire logic [3:0]         I_WB_SEL,    // Byte lanes
    input  wire logic [31:0]        I_WB_DAT,    // Write data
    output logic      [31:0]        O_WB_DAT,    // Read data
    output logic                    O_WB_ACK,    // Acknowledge
    input  wire logic               I_NO_SIGNAL, // Receiver no signal, pin
    input  wire lnini_pkg::lnini_rxw_t I_RX_WORD, // Decoded rx word
    output lnini_pkg::lnini_lane_t  O_LANE,      // Lane power and modes
    output lnini_pkg::lnini_state_t O_STATE,     // Current state
    output logic      [7:0]         O_RECEIVE_ERROR_WORD_CNT, // Rx error word counter
    output logic                    O_RECEIVE_ERROR_WORD_LOAD // Counter loaded pulse
);
    lnini_pkg::lnini_state_t state_q;
    lnini_pkg::lnini_state_t state_d;
    lnini_pkg::lnini_lane_t  lane_q;
    lnini_pkg::lnini_lane_t  lane_d;

    logic                          ns_meta_q;
    logic                          ns_q;
    logic                          start_q;
    logic                          auto_q;
    logic                          full_cmd_q;
    logic                          part_cmd_q;
    logic [7:0]                    rxe_init_q;
    logic [7:0]                    receive_error_word_q;
    logic                          load_q;
    logic                          ack_q;
    logic [31:0]                   rdat_q;
    logic [lnini_pkg::FLUSH_W-1:0] flush_cnt_q;
    logic [lnini_pkg::TMO_W-1:0]   tmo_cnt_q;
    logic                          inv_q;

    logic       req;
    logic       wr;
    logic       up;
    logic       flush_done;
    logic       tmo_run;
    logic       tmo_exp;
    logic       los_full;
    logic       stby_full;
    logic       drop;
    logic [3:0] hs_full;
    logic       hs_ok;
    logic       hs_inv;
    logic       run_clr;
    logic       entry;
    logic       rxv;

    // Receiver status pin crosses into the clock domain
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            ns_meta_q <= 1'b1;
            ns_q      <= 1'b1;
        end
        else
        begin
            ns_meta_q <= I_NO_SIGNAL;
            ns_q      <= ns_meta_q;
        end
    end

    // Register port
    assign req = I_WB_CYC && I_WB_STB && !ack_q;
    assign wr  = req && I_WB_WE && I_WB_SEL[0];

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
            ack_q <= 1'b0;
        else
            ack_q <= req;
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST || state_q == lnini_pkg::ST_COLD)
        begin
            start_q <= 1'b0;
            auto_q  <= 1'b0;
        end
        else if (wr && I_WB_ADR == lnini_pkg::ADR_CTRL)
        begin
            start_q <= I_WB_DAT[lnini_pkg::CTRL_START];
            auto_q  <= I_WB_DAT[lnini_pkg::CTRL_AUTO];
        end
    end

    // Reset commands are one-cycle pulses from a write of one
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            full_cmd_q <= 1'b0;
            part_cmd_q <= 1'b0;
        end
        else
        begin
            full_cmd_q <= wr && I_WB_ADR == lnini_pkg::ADR_CTRL
                          && I_WB_DAT[lnini_pkg::CTRL_FULL];
            part_cmd_q <= wr && I_WB_ADR == lnini_pkg::ADR_CTRL
                          && I_WB_DAT[lnini_pkg::CTRL_PART];
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST || state_q == lnini_pkg::ST_COLD)
            rxe_init_q <= lnini_pkg::RXE_INIT_RST;
        else if (wr && I_WB_ADR == lnini_pkg::ADR_RXE)
            rxe_init_q <= I_WB_DAT[7:0];
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
            rdat_q <= 32'h0000_0000;
        else if (req && !I_WB_WE)
        begin
            rdat_q <= 32'h0000_0000;
            case (I_WB_ADR)
                lnini_pkg::ADR_CTRL:
                begin
                    rdat_q[lnini_pkg::CTRL_START] <= start_q;
                    rdat_q[lnini_pkg::CTRL_AUTO]  <= auto_q;
                end
                lnini_pkg::ADR_STAT:
                begin
                    rdat_q[2:0]                   <= state_q;
                    rdat_q[lnini_pkg::STAT_TX]    <= lane_q.tx_drv;
                    rdat_q[lnini_pkg::STAT_RX]    <= lane_q.rx;
                    rdat_q[lnini_pkg::STAT_INV]   <= inv_q;
                    rdat_q[lnini_pkg::STAT_TMR]   <= tmo_run;
                    rdat_q[lnini_pkg::STAT_NOSIG] <= ns_q;
                    rdat_q[lnini_pkg::STAT_ERR+:8] <= receive_error_word_q;
                end
                lnini_pkg::ADR_RXE:
                    rdat_q[7:0] <= rxe_init_q;
                default:
                    rdat_q <= 32'h0000_0000;
            endcase
        end
    end

    assign O_WB_ACK = ack_q;
    assign O_WB_DAT = rdat_q;

    // Word run counters
    assign rxv     = I_RX_WORD.valid;
    assign run_clr = (state_d != state_q);

    lnini_run_cnt #(
        .LIMIT (lnini_pkg::DROP_RUN)
    ) u_los_run (
        .i_clk  (I_CLK),
        .i_srst (I_SRST),
        .i_clr  (1'b0),
        .i_hit  (rxv && I_RX_WORD.kind == lnini_pkg::W_LOS),
        .i_brk  (rxv && I_RX_WORD.kind != lnini_pkg::W_LOS),
        .o_full (los_full)
    );

    lnini_run_cnt #(
        .LIMIT (lnini_pkg::DROP_RUN)
    ) u_stby_run (
        .i_clk  (I_CLK),
        .i_srst (I_SRST),
        .i_clr  (1'b0),
        .i_hit  (rxv && I_RX_WORD.kind == lnini_pkg::W_STBY),
        .i_brk  (rxv && I_RX_WORD.kind != lnini_pkg::W_STBY),
        .o_full (stby_full)
    );

    for (genvar g = 0; g < 4; g++)
    begin : g_hs
        localparam logic [2:0] K = 3'(int'(lnini_pkg::W_FIRST_HANDSHAKE_WORD) + g);
        logic is_hs;
        assign is_hs = I_RX_WORD.kind >= lnini_pkg::W_FIRST_HANDSHAKE_WORD
                       && I_RX_WORD.kind <= lnini_pkg::W_NINIT2;
        lnini_run_cnt #(
            .LIMIT (lnini_pkg::HS_RUN)
        ) u_hs_run (
            .i_clk  (I_CLK),
            .i_srst (I_SRST),
            .i_clr  (run_clr),
            .i_hit  (rxv && I_RX_WORD.kind == K),
            .i_brk  (rxv && I_RX_WORD.kind != K
                     && (is_hs || I_RX_WORD.kind == lnini_pkg::W_RECEIVE_ERROR_WORD)),
            .o_full (hs_full[g])
        );
    end

    assign drop   = los_full || stby_full;
    assign hs_ok  = hs_full[0] || hs_full[1];
    assign hs_inv = hs_full[2] || hs_full[3];
    assign up     = start_q || auto_q;

    // Flush dwell timer
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST || state_q != lnini_pkg::ST_FLUSH)
            flush_cnt_q <= '0;
        else if (!flush_done)
            flush_cnt_q <= flush_cnt_q + 1'b1;
    end

    assign flush_done = (flush_cnt_q == lnini_pkg::FLUSH_W'(
                         lnini_pkg::FLUSH_CYC - 1));

    // Initialisation timeout, kept through the later states
    assign tmo_run = state_q == lnini_pkg::ST_START
                     || state_q == lnini_pkg::ST_FLIP
                     || state_q == lnini_pkg::ST_CONN;
    assign tmo_exp = tmo_cnt_q == lnini_pkg::TMO_W'(lnini_pkg::TMO_CYC - 1);
    assign entry   = state_q == lnini_pkg::ST_WAIT
                     && state_d == lnini_pkg::ST_START;

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST || entry)
            tmo_cnt_q <= '0;
        else if (tmo_run && !tmo_exp)
            tmo_cnt_q <= tmo_cnt_q + 1'b1;
    end

    // Next state, exits in priority order
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            lnini_pkg::ST_COLD:
                state_d = lnini_pkg::ST_FLUSH;
            lnini_pkg::ST_FLUSH:
                if (full_cmd_q)
                    state_d = lnini_pkg::ST_COLD;
                else if (flush_done)
                    state_d = lnini_pkg::ST_DIS;
            lnini_pkg::ST_DIS:
                if (full_cmd_q)
                    state_d = lnini_pkg::ST_COLD;
                else if (part_cmd_q)
                    state_d = lnini_pkg::ST_FLUSH;
                else if (up)
                    state_d = lnini_pkg::ST_WAIT;
                else if (drop)
                    state_d = lnini_pkg::ST_FLUSH;
            lnini_pkg::ST_WAIT:
                if (full_cmd_q)
                    state_d = lnini_pkg::ST_COLD;
                else if (part_cmd_q)
                    state_d = lnini_pkg::ST_FLUSH;
                else if (!up)
                    state_d = lnini_pkg::ST_DIS;
                else if (start_q || !ns_q)
                    state_d = lnini_pkg::ST_START;
                else if (drop)
                    state_d = lnini_pkg::ST_FLUSH;
            lnini_pkg::ST_START:
                if (full_cmd_q)
                    state_d = lnini_pkg::ST_COLD;
                else if (part_cmd_q)
                    state_d = lnini_pkg::ST_FLUSH;
                else if (hs_ok)
                    state_d = lnini_pkg::ST_CONN;
                else if (hs_inv)
                    state_d = lnini_pkg::ST_FLIP;
                else if (tmo_exp)
                    state_d = lnini_pkg::ST_FLUSH;
                else if (drop)
                    state_d = lnini_pkg::ST_FLUSH;
            lnini_pkg::ST_FLIP, lnini_pkg::ST_CONN:
                if (full_cmd_q)
                    state_d = lnini_pkg::ST_COLD;
                else if (part_cmd_q || ns_q)
                    state_d = lnini_pkg::ST_FLUSH;
                else if (hs_ok && state_q == lnini_pkg::ST_FLIP)
                    state_d = lnini_pkg::ST_CONN;
                else if (tmo_exp || drop)
                    state_d = lnini_pkg::ST_FLUSH;
            default:
                state_d = lnini_pkg::ST_FLUSH;
        endcase
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
            state_q <= lnini_pkg::ST_COLD;
        else
            state_q <= state_d;
    end

    // Lane power follows the next state
    always_comb
    begin
        lane_d = '0;
        case (state_d)
            lnini_pkg::ST_WAIT:
            begin
                lane_d.rx     = 1'b1;
                lane_d.rx_cdr = 1'b1;
                lane_d.lane_control_word   = 1'b1;
            end
            lnini_pkg::ST_START, lnini_pkg::ST_FLIP, lnini_pkg::ST_CONN:
            begin
                lane_d.tx_drv     = 1'b1;
                lane_d.tx_pll     = 1'b1;
                lane_d.rx         = 1'b1;
                lane_d.rx_cdr     = 1'b1;
                lane_d.lane_control_word       = 1'b1;
                lane_d.send_first_handshake_word = (state_d == lnini_pkg::ST_START);
            end
            default:
                lane_d = '0;
        endcase
        lane_d.rx_inv = inv_q;
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST || state_d == lnini_pkg::ST_FLUSH)
            inv_q <= 1'b0;
        else if (state_d == lnini_pkg::ST_FLIP)
            inv_q <= 1'b1;
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
            lane_q <= '0;
        else
            lane_q <= lane_d;
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            receive_error_word_q <= 8'h00;
            load_q  <= 1'b0;
        end
        else
        begin
            load_q <= run_clr && (state_d == lnini_pkg::ST_START
                                  || state_d == lnini_pkg::ST_FLIP);
            if (run_clr && (state_d == lnini_pkg::ST_START
                            || state_d == lnini_pkg::ST_FLIP))
                receive_error_word_q <= rxe_init_q;
        end
    end

    assign O_LANE       = '{tx_drv:lane_q.tx_drv, tx_pll:lane_q.tx_pll,
                            rx:lane_q.rx, rx_cdr:lane_q.rx_cdr,
                            lane_control_word:lane_q.lane_control_word, rx_inv:inv_q,
                            send_first_handshake_word:lane_q.send_first_handshake_word};
    assign O_STATE      = state_q;
    assign O_RECEIVE_ERROR_WORD_CNT  = receive_error_word_q;
    assign O_RECEIVE_ERROR_WORD_LOAD = load_q;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SRST);

    property p_flush_dwell;
        state_q == lnini_pkg::ST_DIS && $past(state_q) == lnini_pkg::ST_FLUSH
            |-> $past(state_q, lnini_pkg::FLUSH_CYC) == lnini_pkg::ST_FLUSH;
    endproperty
    a_flush_dwell: assert property (p_flush_dwell)
        else $error("flush left too early");

    property p_dis_off;
        state_q == lnini_pkg::ST_DIS |-> !O_LANE.tx_drv && !O_LANE.tx_pll
            && !O_LANE.rx && !O_LANE.rx_cdr;
    endproperty
    a_dis_off: assert property (p_dis_off)
        else $error("lane powered while disabled");

    property p_full_first;
        (state_q == lnini_pkg::ST_DIS || state_q == lnini_pkg::ST_WAIT
         || state_q == lnini_pkg::ST_START) && full_cmd_q
            |=> state_q == lnini_pkg::ST_COLD ##1
                state_q == lnini_pkg::ST_FLUSH;
    endproperty
    a_full_first: assert property (p_full_first)
        else $error("full reset not taken");

    property p_part_next;
        (state_q == lnini_pkg::ST_DIS || state_q == lnini_pkg::ST_WAIT)
            && !full_cmd_q && part_cmd_q |=> state_q == lnini_pkg::ST_FLUSH;
    endproperty
    a_part_next: assert property (p_part_next)
        else $error("partial reset not taken");

    property p_dis_wait;
        state_q == lnini_pkg::ST_DIS && !full_cmd_q && !part_cmd_q && up
            |=> state_q == lnini_pkg::ST_WAIT && O_LANE.rx && !O_LANE.tx_drv;
    endproperty
    a_dis_wait: assert property (p_dis_wait)
        else $error("bring-up request ignored");

    property p_wait_back;
        state_q == lnini_pkg::ST_WAIT && !full_cmd_q && !part_cmd_q
            && !start_q && !auto_q |=> state_q == lnini_pkg::ST_DIS;
    endproperty
    a_wait_back: assert property (p_wait_back)
        else $error("wait did not fall back");

    property p_wait_go;
        state_q == lnini_pkg::ST_WAIT && !full_cmd_q && !part_cmd_q && up
            && (start_q || !ns_q) |=> state_q == lnini_pkg::ST_START
            && tmo_cnt_q == '0 && O_RECEIVE_ERROR_WORD_LOAD;
    endproperty
    a_wait_go: assert property (p_wait_go)
        else $error("wait did not start");

    property p_drop;
        !full_cmd_q && !part_cmd_q && drop
            && (state_q == lnini_pkg::ST_DIS && !up
                || state_q == lnini_pkg::ST_START && !hs_ok && !hs_inv
                   && !tmo_exp)
            |=> state_q == lnini_pkg::ST_FLUSH;
    endproperty
    a_drop: assert property (p_drop)
        else $error("word run exit missed");

    property p_tmo;
        state_q == lnini_pkg::ST_START && tmo_exp && !full_cmd_q
            && !part_cmd_q && !hs_ok && !hs_inv
            |=> state_q == lnini_pkg::ST_FLUSH ##1 !O_LANE.rx_inv;
    endproperty
    a_tmo: assert property (p_tmo)
        else $error("timeout exit missed");

    property p_hs;
        state_q == lnini_pkg::ST_START && !full_cmd_q && !part_cmd_q
            && hs_ok |=> state_q == lnini_pkg::ST_CONN && O_LANE.tx_drv;
    endproperty
    a_hs: assert property (p_hs)
        else $error("handshake exit missed");

    property p_inv;
        state_q == lnini_pkg::ST_START && !full_cmd_q && !part_cmd_q
            && !hs_ok && hs_inv |=> state_q == lnini_pkg::ST_FLIP
            && O_LANE.rx_inv;
    endproperty
    a_inv: assert property (p_inv)
        else $error("inverted handshake exit missed");

    property p_start_lane;
        state_q == lnini_pkg::ST_START |-> O_LANE.send_first_handshake_word
            && O_LANE.tx_pll && O_LANE.lane_control_word && receive_error_word_q == $past(rxe_init_q, 1)
            || $past(state_q) == lnini_pkg::ST_START;
    endproperty
    a_start_lane: assert property (p_start_lane)
        else $error("started lane setup wrong");

    c_to_conn: cover property (state_q == lnini_pkg::ST_CONN);
    c_to_flip: cover property (state_q == lnini_pkg::ST_FLIP);
    c_tmo:     cover property (state_q == lnini_pkg::ST_START && tmo_exp);
    c_back:    cover property (state_q == lnini_pkg::ST_WAIT && !up);
endmodule

// ### src/lnini_pkg.sv
// Constants and types for the lane bring-up state machine.
// Assumes a 20 MHz clock and a classic Wishbone register port.
// Function
// - Leave line flush for Disabled only after two microseconds there.
// - Disabled keeps transmit driver, transmit PLL, receiver and recovery off.
// - Disabled, Wait and Started test exits in fixed order, first wins.
// - Full lane reset goes to cold reset; then partial reset to flush.
// - Disabled goes to Wait on bring-up request or automatic bring-up.
// - Lowest exit: 8 consecutive signal-lost or standby words go to flush.
// - Wait keeps transmitter off, receiver and recovery on, control words on.
// - Wait returns to Disabled when request and automatic bring-up both low.
// - Wait goes to Started on request, or when receive signal present.
// - Entering Started starts a 20 us timeout that later states keep.
// - Started enables everything and sends first handshake words.
// - Started receives control words and loads the receive-error counter.
// - Three straight handshake words without receive error go to Connecting.
// - Three straight inverted handshake words go to the polarity-flip state.
// - Started goes to line flush when the timeout expires first.
// - Line flush switches receive inversion off; only polarity flip sets it.

package lnini_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int FLUSH_TIME_NS = 2000;
    localparam int FLUSH_CYC     = (FLUSH_TIME_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int FLUSH_W       = 6;
    localparam int INIT_TMO_NS   = 20000;
    localparam int TMO_CYC       = (INIT_TMO_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int TMO_W         = 9;
    localparam int DROP_RUN      = 8;
    localparam int HS_RUN        = 3;

    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [7:0] ADR_RXE  = 8'h08;

    localparam int CTRL_START = 0;
    localparam int CTRL_AUTO  = 1;
    localparam int CTRL_FULL  = 2;
    localparam int CTRL_PART  = 3;

    localparam int STAT_TX    = 3;
    localparam int STAT_RX    = 4;
    localparam int STAT_INV   = 5;
    localparam int STAT_TMR   = 6;
    localparam int STAT_NOSIG = 7;
    localparam int STAT_ERR   = 8;

    localparam logic [7:0] RXE_INIT_RST = 8'h08;

    typedef enum logic [2:0] {
        ST_COLD  = 3'h0,
        ST_FLUSH = 3'h1,
        ST_DIS   = 3'h3,
        ST_WAIT  = 3'h2,
        ST_START = 3'h6,
        ST_CONN  = 3'h7,
        ST_FLIP  = 3'h5
    } lnini_state_t;

    typedef enum logic [2:0] {
        W_OTHER  = 3'h0,
        W_LOS    = 3'h1,
        W_STBY   = 3'h2,
        W_FIRST_HANDSHAKE_WORD  = 3'h3,
        W_SECOND_HANDSHAKE_WORD  = 3'h4,
        W_NINIT1 = 3'h5,
        W_NINIT2 = 3'h6,
        W_RECEIVE_ERROR_WORD  = 3'h7
    } lnini_word_t;

    typedef struct packed {
        logic        valid;
        lnini_word_t kind;
    } lnini_rxw_t;

    typedef struct packed {
        logic tx_drv;
        logic tx_pll;
        logic rx;
        logic rx_cdr;
        logic lane_control_word;
        logic rx_inv;
        logic send_first_handshake_word;
    } lnini_lane_t;
endpackage

// ### src/lnini_run_cnt.sv
// Counter of consecutive received words of one kind.
// Assumes hit and break are never high together.
`timescale 1ns/1ps

module lnini_run_cnt #(
    parameter int LIMIT = 8
) (
    input  wire logic i_clk,   // System clock
    input  wire logic i_srst,  // Sync reset, high
    input  wire logic i_clr,   // Restart count
    input  wire logic i_hit,   // Matching word seen
    input  wire logic i_brk,   // Breaking word seen
    output logic      o_full   // LIMIT reached
);
    localparam int W = $clog2(LIMIT + 1);

    logic [W-1:0] cnt_q;

    always_ff @(posedge i_clk)
    begin
        if (i_srst || i_clr || i_brk)
            cnt_q <= '0;
        else if (i_hit && !o_full)
            cnt_q <= cnt_q + 1'b1;
    end

    assign o_full = (cnt_q == W'(LIMIT));

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    property p_brk_restart;
        i_brk |=> cnt_q == '0;
    endproperty
    a_brk_restart: assert property (p_brk_restart)
        else $error("run count not restarted");

    property p_hit_step;
        !i_clr && i_hit && !o_full |=> cnt_q == $past(cnt_q) + 1'b1;
    endproperty
    a_hit_step: assert property (p_hit_step)
        else $error("run count did not advance");

    c_full: cover property (!i_clr && !i_brk ##1 o_full);
endmodule
